// ### design/crd_pkg.sv
package crd_pkg;
  // bus geometry
  localparam int unsigned CRD_ADDR_W = 5;
  localparam int unsigned CRD_DATA_W = 32;
  localparam int unsigned CRD_ROWS = 12;
  localparam int unsigned CRD_ALARMS = 4;

  // register byte offsets
  localparam logic [4:0] CRD_CTRL_OFS = 5'h00;
  localparam logic [4:0] CRD_CMD_OFS = 5'h04;
  localparam logic [4:0] CRD_DATA_OFS = 5'h08;
  localparam logic [4:0] CRD_STATUS_OFS = 5'h0C;
  localparam logic [4:0] CRD_ERRTEST_OFS = 5'h10;

  // control register fields
  localparam int unsigned CRD_CTRL_TIM_BIT = 0;
  localparam int unsigned CRD_CTRL_PACK_BIT = 1;
  localparam int unsigned CRD_CTRL_EOR_INH_BIT = 2;
  // command register fields
  localparam int unsigned CRD_CMD_OPR_BIT = 0;
  localparam int unsigned CRD_CMD_ABT_BIT = 1;
  // status register fields
  localparam int unsigned CRD_ST_READY_BIT = 0;
  localparam int unsigned CRD_ST_BUSY_BIT = 1;
  localparam int unsigned CRD_ST_CLUTCH_BIT = 2;
  localparam int unsigned CRD_ST_DRY_BIT = 3;
  localparam int unsigned CRD_ST_DEMAND_BIT = 4;
  localparam int unsigned CRD_ST_DRE_BIT = 5;
  localparam int unsigned CRD_ST_ALARM_LSB = 8;
  // error test register fields
  localparam int unsigned CRD_ERR_LINE_BIT = 0;
  localparam int unsigned CRD_ERR_SEL_LSB = 8;
  localparam int unsigned CRD_TIMING_ALARM = 3;

  // packed-mode position of row 9
  localparam int unsigned CRD_PACK_SHIFT = 12;

  // synchronised pin vector layout
  localparam int unsigned CRD_PIN_ROW_LSB = 0;
  localparam int unsigned CRD_PIN_COLCLK_N = 12;
  localparam int unsigned CRD_PIN_CARD_END = 13;
  localparam int unsigned CRD_PIN_DEMAND = 14;
  localparam int unsigned CRD_PIN_ONLINE = 15;
  localparam int unsigned CRD_PIN_CONNECTED = 16;
  localparam int unsigned CRD_PIN_ALARM_LSB = 17;
  localparam int unsigned CRD_PIN_W = 20;

  // values after reset
  localparam logic CRD_WAIT_RST = 1'b1;
  localparam logic CRD_READY_RST = 1'b1;

  // bus handshake phase, gray along idle -> done
  typedef enum logic [0:0] {
    CRD_BUS_IDLE = 1'b0,
    CRD_BUS_DONE = 1'b1
  } crd_bus_type;
endpackage

// ### design/crd_pin_if.sv
`timescale 1ns/1ps
interface crd_pin_if;
  logic [11:0] card_rows;
  logic column_clock_pulse_n;
  logic online_card_end_signal;
  logic demand_button_input;
  logic reader_online;
  logic reader_connected;
  logic [2:0] alarm_inputs;

  modport sync_mp (
    output card_rows,
    output column_clock_pulse_n,
    output online_card_end_signal,
    output demand_button_input,
    output reader_online,
    output reader_connected,
    output alarm_inputs
  );
  modport ctl_mp (
    input card_rows,
    input column_clock_pulse_n,
    input online_card_end_signal,
    input demand_button_input,
    input reader_online,
    input reader_connected,
    input alarm_inputs
  );
endinterface

// ### design/crd_pin_sync.sv
`timescale 1ns/1ps
module crd_pin_sync
  import crd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [CRD_PIN_W-1:0] i_raw_pins,
  crd_pin_if.sync_mp pins
);
  typedef struct packed {
    logic [CRD_PIN_W-1:0] stage1;
    logic [CRD_PIN_W-1:0] stage2;
  } crd_sync_state_type;

  crd_sync_state_type st_ff;
  crd_sync_state_type nxt_st;

  // two stages per pin; stage1 feeds only stage2
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage1 = i_raw_pins;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pins.card_rows = st_ff.stage2[CRD_PIN_ROW_LSB +: 12];
  assign pins.column_clock_pulse_n = st_ff.stage2[CRD_PIN_COLCLK_N];
  assign pins.online_card_end_signal = st_ff.stage2[CRD_PIN_CARD_END];
  assign pins.demand_button_input = st_ff.stage2[CRD_PIN_DEMAND];
  assign pins.reader_online = st_ff.stage2[CRD_PIN_ONLINE];
  assign pins.reader_connected = st_ff.stage2[CRD_PIN_CONNECTED];
  assign pins.alarm_inputs = st_ff.stage2[CRD_PIN_ALARM_LSB +: 3];
endmodule

// ### design/crd_reader_ctl.sv
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Functional notes
// R01: normal transfer puts row 9 at word bit 0, row 12 at bit 11.
// R02: timed block input puts row 9 at bit 0 or 12 by packing mode.
// R03: each operate starts one card feed; accumulator contents ignored.
// R04: alarm test line ORs four alarms, each selectable by error test.
// R05: alarms: halt/off-line, jam/feed/power/light, hopper/stacker, timing error.
// R06: card is 80 columns of 12 rows; one input per character.
// R07: busy cleared at record end and by abort.
// R08: ready test line high only when not busy and no demand pending.
// R09: demand button, two-stage synchronised, latches demand, clears busy, ready irq.
// R10: operate sets busy; busy sets clutch when on-line; clears ready line.
// R11: clutch drives feed; column clock pulse times the control logic.
// R12: low column clock with clutch sets sequence flag, delay flag follows.
// R13: read window follows sequence flag; data register loads only in window.
// R14: data ready enable is set whenever a reader is connected.
// R15: gap pulse sets data ready; data ready raises data exchange irq.
// R16: processor answers each data exchange irq with an input command.
// R17: input command clears data ready.
// R18: card end clears busy and clutch, raises end-of-record irq.
// R19: processor must issue another operate before the next card feeds.
// R20: new column while data ready still set raises timing error alarm.
// R21: data exchange irq not inhibitable; end-of-record irq inhibitable.
// R22: reset clears busy, clutch, sequence, data ready, demand and alarms.
// R23: timing error stays set until sampled by error test or reset.
module crd_reader_ctl
  import crd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [CRD_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [CRD_DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [CRD_DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [11:0] i_card_rows,
  input wire logic i_column_clock_pulse_n,
  input wire logic i_online_card_end_signal,
  input wire logic i_demand_button_input,
  input wire logic i_reader_online,
  input wire logic i_reader_connected,
  input wire logic i_alarm_halt_offline,
  input wire logic i_alarm_jam_power,
  input wire logic i_alarm_hopper_stacker,
  output logic o_clutch_relay_drive,
  output logic o_read_window_drive,
  output logic o_ready_test_line,
  output logic o_alarm_test_line,
  output logic o_data_exchange_irq,
  output logic o_channel_ready_irq,
  output logic o_end_record_irq
);
  typedef struct packed {
    crd_bus_type bus;
    logic wait_req;
    logic [CRD_DATA_W-1:0] rdata;
    logic channel_busy_flag;
    logic feed_clutch_flag;
    logic column_sequence_flag;
    logic sequence_delay_flag;
    logic [11:0] data_reg;
    logic data_ready_enable_flag;
    logic data_ready_flag;
    logic manual_demand_latch;
    logic demand_prev;
    logic card_end_prev;
    logic ready_test_line;
    logic alarm_test_line;
    logic [CRD_ALARMS-1:0] alarm_flag;
    logic [CRD_ALARMS-1:0] alarm_select;
    logic tim_enable;
    logic pack_high;
    logic eor_inhibit;
    logic data_exchange_irq;
    logic channel_ready_irq;
    logic end_record_irq;
  } crd_ctl_state_type;

  crd_ctl_state_type st_ff;
  crd_ctl_state_type nxt_st;

  crd_pin_if pins ();

  logic [CRD_PIN_W-1:0] raw_pins;
  logic req;
  logic done;
  logic wr_done;
  logic rd_done;
  logic operate_cmd;
  logic abort_cmd;
  logic input_cmd;
  logic err_test_cmd;
  logic col_low;
  logic first_col;
  logic data_register_clear;
  logic column_control_pulse;
  logic demand_rise;
  logic card_end_fall;
  logic [23:0] au_word;
  logic [CRD_ALARMS-1:0] alarm_vec;

  ////////////////////////////////////////////////////////////////////////////
  // every pin crosses two flops before the control logic sees it
  assign raw_pins = {i_alarm_hopper_stacker, i_alarm_jam_power, i_alarm_halt_offline,
                     i_reader_connected, i_reader_online, i_demand_button_input,
                     i_online_card_end_signal, i_column_clock_pulse_n, i_card_rows};

  crd_pin_sync crd_pin_sync_inst (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_raw_pins(raw_pins),
    .pins(pins.sync_mp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus strobes: a request completes on the edge where waitrequest is low
  assign req = i_avs_read | i_avs_write;
  assign done = (st_ff.bus == CRD_BUS_DONE) & req;
  assign wr_done = done & i_avs_write & i_avs_byteenable[0];
  assign rd_done = done & i_avs_read;
  // accumulator bits beside the command field are never looked at
  assign operate_cmd = wr_done & (i_avs_address == CRD_CMD_OFS) &
                       i_avs_writedata[CRD_CMD_OPR_BIT]; // R03
  assign abort_cmd = wr_done & (i_avs_address == CRD_CMD_OFS) &
                     i_avs_writedata[CRD_CMD_ABT_BIT];
  assign input_cmd = rd_done & (i_avs_address == CRD_DATA_OFS); // R06
  assign err_test_cmd = rd_done & (i_avs_address == CRD_ERRTEST_OFS);

  // column timing events
  assign col_low = ~pins.column_clock_pulse_n; // R11
  assign first_col = st_ff.column_sequence_flag & ~st_ff.sequence_delay_flag;
  assign data_register_clear = first_col; // R12
  assign column_control_pulse = st_ff.sequence_delay_flag & ~st_ff.column_sequence_flag;
  assign demand_rise = pins.demand_button_input & ~st_ff.demand_prev;
  assign card_end_fall = st_ff.card_end_prev & ~pins.online_card_end_signal;

  // character as presented to the arithmetic unit
  always_comb begin
    au_word = {12'h000, st_ff.data_reg}; // R01
    if (st_ff.tim_enable && st_ff.pack_high) begin
      au_word = {st_ff.data_reg, 12'h000}; // R02
    end
  end

  // alarm 4 is sticky, the others follow their inputs
  assign alarm_vec = {st_ff.alarm_flag[CRD_TIMING_ALARM], st_ff.alarm_flag[2:0]}; // R05

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for the whole channel
  always_comb begin
    nxt_st = st_ff;
    // bus handshake, one wait cycle for every access
    if (st_ff.bus == CRD_BUS_IDLE) begin
      if (req) begin
        nxt_st.bus = CRD_BUS_DONE;
        nxt_st.wait_req = 1'b0;
        nxt_st.rdata = '0;
        // unmapped offsets read zero
        if (i_avs_address == CRD_CTRL_OFS) begin
          nxt_st.rdata[CRD_CTRL_TIM_BIT] = st_ff.tim_enable;
          nxt_st.rdata[CRD_CTRL_PACK_BIT] = st_ff.pack_high;
          nxt_st.rdata[CRD_CTRL_EOR_INH_BIT] = st_ff.eor_inhibit;
        end else if (i_avs_address == CRD_DATA_OFS) begin
          nxt_st.rdata[23:0] = au_word;
        end else if (i_avs_address == CRD_STATUS_OFS) begin
          nxt_st.rdata[CRD_ST_READY_BIT] = st_ff.ready_test_line;
          nxt_st.rdata[CRD_ST_BUSY_BIT] = st_ff.channel_busy_flag;
          nxt_st.rdata[CRD_ST_CLUTCH_BIT] = st_ff.feed_clutch_flag;
          nxt_st.rdata[CRD_ST_DRY_BIT] = st_ff.data_ready_flag;
          nxt_st.rdata[CRD_ST_DEMAND_BIT] = st_ff.manual_demand_latch;
          nxt_st.rdata[CRD_ST_DRE_BIT] = st_ff.data_ready_enable_flag;
          nxt_st.rdata[CRD_ST_ALARM_LSB +: 4] = alarm_vec;
        end else if (i_avs_address == CRD_ERRTEST_OFS) begin
          nxt_st.rdata[CRD_ERR_LINE_BIT] = |(alarm_vec & st_ff.alarm_select); // R04
          nxt_st.rdata[CRD_ERR_SEL_LSB +: 4] = st_ff.alarm_select;
        end
      end
    end else begin
      nxt_st.bus = CRD_BUS_IDLE;
      nxt_st.wait_req = CRD_WAIT_RST;
    end

    // configuration writes
    if (wr_done && (i_avs_address == CRD_CTRL_OFS)) begin
      nxt_st.tim_enable = i_avs_writedata[CRD_CTRL_TIM_BIT];
      nxt_st.pack_high = i_avs_writedata[CRD_CTRL_PACK_BIT];
      nxt_st.eor_inhibit = i_avs_writedata[CRD_CTRL_EOR_INH_BIT];
    end
    if (wr_done && (i_avs_address == CRD_ERRTEST_OFS)) begin
      nxt_st.alarm_select = i_avs_writedata[CRD_ERR_SEL_LSB +: 4]; // R04
    end

    // edge history of slow reader signals
    nxt_st.demand_prev = pins.demand_button_input;
    nxt_st.card_end_prev = pins.online_card_end_signal;

    // manual demand: operate takes it, a new press wins
    if (operate_cmd) begin
      nxt_st.manual_demand_latch = 1'b0;
    end
    if (demand_rise) begin
      nxt_st.manual_demand_latch = 1'b1; // R09
    end

    // busy: any clearing cause beats operate in the same cycle
    if (operate_cmd) begin
      nxt_st.channel_busy_flag = 1'b1; // R10
    end
    if (abort_cmd || card_end_fall || demand_rise) begin
      nxt_st.channel_busy_flag = 1'b0; // R07
    end

    // clutch set by busy while on-line; drops only at card end or abort
    if (st_ff.channel_busy_flag && pins.reader_online) begin
      nxt_st.feed_clutch_flag = 1'b1; // R10
    end
    if (abort_cmd || card_end_fall) begin
      nxt_st.feed_clutch_flag = 1'b0; // R18
    end

    // column sequencing runs only with the clutch engaged
    nxt_st.column_sequence_flag = col_low & st_ff.feed_clutch_flag; // R12
    nxt_st.sequence_delay_flag = st_ff.column_sequence_flag; // R12

    // data register: cleared on the first window cycle, rows ORed in after
    if (data_register_clear) begin
      nxt_st.data_reg = pins.card_rows; // R13
    end else if (st_ff.column_sequence_flag) begin
      nxt_st.data_reg = st_ff.data_reg | pins.card_rows; // R13
    end

    // no start code on cards: enable tracks the connection
    nxt_st.data_ready_enable_flag = pins.reader_connected; // R14

    // data ready: an input clears it, a gap pulse sets it and wins
    if (input_cmd) begin
      nxt_st.data_ready_flag = 1'b0; // R17
    end
    if (column_control_pulse && st_ff.data_ready_enable_flag) begin
      nxt_st.data_ready_flag = 1'b1; // R15
    end

    // alarms 1..3 are live; timing error is sticky until sampled
    nxt_st.alarm_flag[2:0] = pins.alarm_inputs; // R05
    if (err_test_cmd && st_ff.alarm_select[CRD_TIMING_ALARM]) begin
      nxt_st.alarm_flag[CRD_TIMING_ALARM] = 1'b0; // R23
    end
    if (first_col && st_ff.data_ready_flag) begin
      nxt_st.alarm_flag[CRD_TIMING_ALARM] = 1'b1; // R20
    end

    // test lines; ready is sampled through the status read, alarm through the error test read
    nxt_st.ready_test_line = ~nxt_st.channel_busy_flag &
                             ~nxt_st.manual_demand_latch; // R08
    nxt_st.alarm_test_line = |({nxt_st.alarm_flag[CRD_TIMING_ALARM],
                                nxt_st.alarm_flag[2:0]} & nxt_st.alarm_select); // R04

    // interrupt lines; only end-of-record honours the inhibit
    nxt_st.data_exchange_irq = nxt_st.data_ready_flag; // R21
    nxt_st.channel_ready_irq = ~nxt_st.channel_busy_flag &
                               nxt_st.manual_demand_latch; // R09
    nxt_st.end_record_irq = card_end_fall & st_ff.channel_busy_flag &
                            ~st_ff.eor_inhibit; // R18
  end

  // single state register; reset leaves the channel idle and ready
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_ff <= '0; // R22
      st_ff.wait_req <= CRD_WAIT_RST;
      st_ff.ready_test_line <= CRD_READY_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // all outputs straight from the state register
  assign o_avs_readdata = st_ff.rdata;
  assign o_avs_waitrequest = st_ff.wait_req;
  assign o_clutch_relay_drive = st_ff.feed_clutch_flag; // R11
  assign o_read_window_drive = st_ff.column_sequence_flag; // R13
  assign o_ready_test_line = st_ff.ready_test_line;
  assign o_alarm_test_line = st_ff.alarm_test_line;
  assign o_data_exchange_irq = st_ff.data_exchange_irq;
  assign o_channel_ready_irq = st_ff.channel_ready_irq;
  assign o_end_record_irq = st_ff.end_record_irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence col_start_s;
    !st_ff.column_sequence_flag ##1 st_ff.column_sequence_flag;
  endsequence
  sequence col_follow_s;
    !st_ff.sequence_delay_flag ##1 st_ff.sequence_delay_flag;
  endsequence

  operate_busy_a: assert property (operate_cmd && !abort_cmd && !demand_rise &&
      !card_end_fall |=> st_ff.channel_busy_flag && !o_ready_test_line) // R10
    else $error("operate did not set busy");
  abort_busy_a: assert property (abort_cmd |=> !st_ff.channel_busy_flag ##1
      !st_ff.feed_clutch_flag) // R07
    else $error("abort did not clear busy");
  ready_line_a: assert property (o_ready_test_line |->
      !st_ff.channel_busy_flag && !st_ff.manual_demand_latch) // R08
    else $error("ready line with busy or demand");
  clutch_cause_a: assert property ($rose(o_clutch_relay_drive) |->
      $past(st_ff.channel_busy_flag) && $past(pins.reader_online)) // R10
    else $error("clutch set without busy on-line");
  seq_follow_a: assert property (col_start_s |-> col_follow_s) // R12
    else $error("delay flag did not follow sequence flag");
  window_load_a: assert property (first_col |=>
      st_ff.data_reg == $past(pins.card_rows)) // R12
    else $error("data register not cleared on first window cycle");
  window_hold_a: assert property (!o_read_window_drive |=> $stable(st_ff.data_reg)) // R13
    else $error("data register changed outside window");
  dry_set_a: assert property (column_control_pulse && st_ff.data_ready_enable_flag
      |=> st_ff.data_ready_flag ##1 o_data_exchange_irq) // R15
    else $error("gap pulse did not raise data ready");
  input_clear_a: assert property (input_cmd && !column_control_pulse |=>
      !st_ff.data_ready_flag ##1 !o_data_exchange_irq) // R17
    else $error("input command did not clear data ready");
  timing_alarm_a: assert property (first_col && st_ff.data_ready_flag |=>
      st_ff.alarm_flag[CRD_TIMING_ALARM]) // R20
    else $error("lost character not flagged");
  alarm_hold_a: assert property ($fell(st_ff.alarm_flag[CRD_TIMING_ALARM]) |->
      $past(err_test_cmd)) // R23
    else $error("timing alarm dropped without error test");
  card_end_a: assert property (card_end_fall && st_ff.channel_busy_flag &&
      !st_ff.eor_inhibit |=> o_end_record_irq && !st_ff.channel_busy_flag &&
      !o_clutch_relay_drive) // R18
    else $error("card end did not end the record");
  demand_a: assert property (demand_rise |=> st_ff.manual_demand_latch &&
      !st_ff.channel_busy_flag ##1 o_channel_ready_irq) // R09
    else $error("demand press not latched");
  bus_answer_a: assert property (req && st_ff.bus == CRD_BUS_IDLE |=> !o_avs_waitrequest)
    else $error("bus request not answered in one cycle");
endmodule

// ### tb/crd_rdr_model.sv
`timescale 1ns/1ps
module crd_rdr_model (
  input wire logic i_sys_clk,
  input wire logic i_clutch,
  output logic [11:0] o_rows,
  output logic o_col_clk_n,
  output logic o_card_end
);
  // idle reader: no hole under the sensor, card not at its end
  initial begin
    o_rows = 12'h000;
    o_col_clk_n = 1'b1;
    o_card_end = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // one column of 12 rows; the belt only moves while the clutch is engaged
  task automatic column(input logic [11:0] pat);
    int n;
    n = 0;
    while (i_clutch !== 1'b1 && n < 200) begin
      @(posedge i_sys_clk);
      n++;
    end
    @(posedge i_sys_clk);
    o_rows <= pat;
    @(posedge i_sys_clk);
    o_col_clk_n <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    o_col_clk_n <= 1'b1;
    // rows held past the hole so the synchronised window closes first
    repeat (4) @(posedge i_sys_clk);
    o_rows <= ~pat;
    repeat (6) @(posedge i_sys_clk);
  endtask

  // end-of-card light check: card end line drops briefly
  task automatic card_end();
    @(posedge i_sys_clk);
    o_card_end <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    o_card_end <= 1'b1;
  endtask
endmodule

// ### tb/crd_reader_ctl_tb.sv
`timescale 1ns/1ps
module crd_reader_ctl_tb;
  import crd_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdata;
  logic wreq;
  logic [11:0] rows;
  logic colclk_n;
  logic card_end;
  logic dem = 1'b0;
  logic onl = 1'b1;
  logic [2:0] alm = 3'h0;
  logic clutch, win, rdy, alt, dxi, cri, eor;
  logic [31:0] q;
  int err_count = 0;
  int cmp_count = 0;
  int wn;

  `define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
  `define WAIT(c) begin wn = 0; while (!(c) && wn < 300) begin @(posedge i_sys_clk); \
    wn++; end if (!(c)) err_count++; end

  // clock and watchdog; 25000 cycles is far beyond the few hundred the tests need
  always #4 i_sys_clk = ~i_sys_clk;
  initial begin
    #200000;
    err_count++;
    test_done();
  end

  crd_reader_ctl crd_reader_ctl_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'h1), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_card_rows(rows), .i_column_clock_pulse_n(colclk_n),
    .i_online_card_end_signal(card_end), .i_demand_button_input(dem),
    .i_reader_online(onl), .i_reader_connected(1'b1), .i_alarm_halt_offline(alm[0]),
    .i_alarm_jam_power(alm[1]), .i_alarm_hopper_stacker(alm[2]),
    .o_clutch_relay_drive(clutch), .o_read_window_drive(win), .o_ready_test_line(rdy),
    .o_alarm_test_line(alt), .o_data_exchange_irq(dxi), .o_channel_ready_irq(cri),
    .o_end_record_irq(eor));
  crd_rdr_model crd_rdr_model_inst (.i_sys_clk(i_sys_clk), .i_clutch(clutch),
    .o_rows(rows), .o_col_clk_n(colclk_n), .o_card_end(card_end));

  ////////////////////////////////////////////////////////////////////////
  // avalon access: request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    wn = 0;
    do begin
      @(posedge i_sys_clk);
      wn++;
    end while (wreq !== 1'b0 && wn < 50);
    // a slave that never answers counts against the run
    if (wreq !== 1'b0) begin
      err_count++;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // data ready enable reaches the status three cycles after the pins settle
  task automatic t_reset();
    repeat (4) @(posedge i_sys_clk);
    bus(1'b0, CRD_STATUS_OFS, 32'h0);
    `CHK("status", 32'h0000_0021, q)
    `CHK("ready", 1'b1, rdy)
    $display("test reset done");
  endtask

  // stray accumulator bits ride along with the operate bit
  task automatic t_operate();
    bus(1'b1, CRD_CMD_OFS, 32'hABCD_EF01);
    `WAIT(clutch === 1'b1)
    bus(1'b0, CRD_STATUS_OFS, 32'h0);
    `CHK("status", 32'h0000_0026, q)
    `CHK("ready", 1'b0, rdy)
    $display("test operate done");
  endtask

  task automatic t_column(input logic [11:0] p, input logic pk);
    bus(1'b1, CRD_CTRL_OFS, {30'h0, pk, pk});
    fork
      crd_rdr_model_inst.column(p);
      begin
        `WAIT(win === 1'b1)
        `CHK("window", 1'b1, win)
      end
    join
    `WAIT(dxi === 1'b1)
    `CHK("irq", 1'b1, dxi)
    bus(1'b0, CRD_DATA_OFS, 32'h0);
    `CHK("data", pk ? {8'h0, p, 12'h000} : {20'h0, p}, q)
    repeat (4) @(posedge i_sys_clk);
    `CHK("irq", 1'b0, dxi)
    $display("test column done");
  endtask

  // second column arrives before the first is taken
  task automatic t_lost();
    crd_rdr_model_inst.column(12'h111);
    crd_rdr_model_inst.column(12'h222);
    bus(1'b0, CRD_STATUS_OFS, 32'h0);
    `CHK("alarms", 32'h0000_0808, q & 32'h0000_0F08)
    bus(1'b1, CRD_ERRTEST_OFS, 32'h0000_0800);
    repeat (5) @(posedge i_sys_clk);
    `CHK("alarm line", 1'b1, alt)
    bus(1'b0, CRD_ERRTEST_OFS, 32'h0);
    `CHK("errtest", 32'h0000_0801, q)
    bus(1'b0, CRD_ERRTEST_OFS, 32'h0);
    `CHK("errtest", 32'h0000_0800, q)
    bus(1'b0, CRD_DATA_OFS, 32'h0);
    $display("test lost done");
  endtask

  // each input alarm shows through its own select bit, not through the next alarm's
  task automatic t_alarms();
    for (int i = 0; i < 3; i++) begin
      alm <= 3'h1 << i;
      bus(1'b1, CRD_ERRTEST_OFS, 32'h100 << i);
      repeat (6) @(posedge i_sys_clk);
      bus(1'b0, CRD_ERRTEST_OFS, 32'h0);
      `CHK("errtest", (32'h100 << i) | 32'h1, q)
      bus(1'b1, CRD_ERRTEST_OFS, 32'h100 << ((i + 1) % 3));
      bus(1'b0, CRD_ERRTEST_OFS, 32'h0);
      `CHK("errtest", 32'h100 << ((i + 1) % 3), q)
    end
    alm <= 3'h0;
    $display("test alarms done");
  endtask

  // the record pulse lasts one cycle, so it is watched while the card ends
  task automatic t_card_end();
    int ne;
    ne = 0;
    fork
      crd_rdr_model_inst.card_end();
      begin
        `WAIT(eor === 1'b1)
        `CHK("eor", 1'b1, eor)
      end
    join
    bus(1'b0, CRD_STATUS_OFS, 32'h0);
    `CHK("status", 32'h0000_0021, q & 32'h0000_0027)
    // inhibited record end: busy still drops, no pulse
    bus(1'b1, CRD_CTRL_OFS, 32'h0000_0004);
    bus(1'b1, CRD_CMD_OFS, 32'h0000_0001);
    `WAIT(clutch === 1'b1)
    `CHK("clutch", 1'b1, clutch)
    fork
      crd_rdr_model_inst.card_end();
      repeat (10) begin
        @(posedge i_sys_clk);
        if (eor !== 1'b0) begin
          ne++;
        end
      end
    join
    `CHK("eor inhibited", 0, ne)
    bus(1'b0, CRD_STATUS_OFS, 32'h0);
    `CHK("status", 32'h0000_0021, q & 32'h0000_0027)
    $display("test card end done");
  endtask

  // off-line reader: busy without clutch until the reader comes back
  task automatic t_offline();
    onl <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    bus(1'b1, CRD_CMD_OFS, 32'h0000_0001);
    repeat (6) @(posedge i_sys_clk);
    `CHK("clutch", 1'b0, clutch)
    onl <= 1'b1;
    `WAIT(clutch === 1'b1)
    `CHK("clutch", 1'b1, clutch)
    bus(1'b1, CRD_CMD_OFS, 32'h0000_0002);
    $display("test offline done");
  endtask

  // demand, then operate clears the latch, abort frees the channel
  task automatic t_demand();
    @(posedge i_sys_clk);
    dem <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    dem <= 1'b0;
    `WAIT(cri === 1'b1)
    `CHK("ready irq", 1'b1, cri)
    `CHK("ready", 1'b0, rdy)
    bus(1'b1, CRD_CMD_OFS, 32'h0000_0001);
    repeat (4) @(posedge i_sys_clk);
    `CHK("ready irq", 1'b0, cri)
    bus(1'b1, CRD_CMD_OFS, 32'h0000_0002);
    repeat (4) @(posedge i_sys_clk);
    bus(1'b0, CRD_STATUS_OFS, 32'h0);
    `CHK("status", 32'h0000_0021, q)
    `CHK("ready", 1'b1, rdy)
    $display("test demand done");
  endtask

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_reset();
    t_operate();
    t_column(12'h001, 1'b0);
    t_column(12'h800, 1'b0);
    t_column(12'h801, 1'b1);
    t_lost();
    t_alarms();
    t_card_end();
    t_offline();
    t_demand();
    test_done();
  end
endmodule
